/* serial_pkg.sv */
// Overview of operation
// - two identical instances, same register behaviour
// - async mode: full duplex, separate pins
// - sync mode: half duplex, master or slave
// - pins serial only while port enable set
// - pin direction from enable and source bits
// - transmit nine bits when tx select set
// - receive nine bits when rx select set
// - single receive takes one byte in sync mode, self clears
// - dedicated 8-bit baud generator, both modes
// - divisor sets free-running timer reload period
// - generator clocks async and sync master only
// - rate fosc/64(x+1) async, fosc/4(x+1) sync
// - divisor write restarts baud timer at once
// - reset clears divisor register
package serial_pkg;
	// register indices as printed, byte address is four times
	localparam logic [7:0] RCV_STATUS_CONTROL_IDX = 8'h13;
	localparam logic [7:0] XMT_STATUS_CONTROL_IDX = 8'h15;
	localparam logic [7:0] BAUD_DIVISOR_IDX       = 8'h17;
	localparam logic [7:0] TX_DATA_IDX            = 8'h18;
	localparam logic [7:0] RX_DATA_IDX            = 8'h19;
	localparam logic [11:0] RCV_ADDR  = {2'h0, RCV_STATUS_CONTROL_IDX, 2'h0};
	localparam logic [11:0] XMT_ADDR  = {2'h0, XMT_STATUS_CONTROL_IDX, 2'h0};
	localparam logic [11:0] BAUD_ADDR = {2'h0, BAUD_DIVISOR_IDX, 2'h0};
	localparam logic [11:0] TXD_ADDR  = {2'h0, TX_DATA_IDX, 2'h0};
	localparam logic [11:0] RXD_ADDR  = {2'h0, RX_DATA_IDX, 2'h0};
	// receive status/control fields
	localparam int RC_PORT_EN       = 7;
	localparam int RC_RX_NINE       = 6;
	localparam int RC_SINGLE_RX     = 5;
	localparam int RC_CONT_RX       = 4;
	localparam int RC_FRAME_ERR     = 2;
	localparam int RC_OVERRUN       = 1;
	localparam int RC_RX_NINTH_DATA = 0;
	// transmit status/control fields
	localparam int TC_CLK_SRC       = 7;
	localparam int TC_TX_NINE       = 6;
	localparam int TC_TX_EN         = 5;
	localparam int TC_SYNC          = 4;
	localparam int TC_SHIFT_EMPTY   = 1;
	localparam int TC_TX_NINTH_DATA = 0;
	// reset values
	localparam logic [7:0] RCV_RESET  = 8'h00;
	localparam logic [7:0] XMT_RESET  = 8'h02;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	// oversampling: async bit = 32 ticks, tick = fosc/2/(x+1)
	// sync master toggles its clock each tick, so a bit is fosc/4/(x+1)
	localparam int ASYNC_TICKS_PER_BIT = 32;
	localparam int FOSC_PER_TICK       = 2;
	localparam logic [1:0] TICK_PRESCALE = 2'(FOSC_PER_TICK - 1);
	localparam logic [4:0] ASYNC_LAST_TICK = 5'(ASYNC_TICKS_PER_BIT - 1);
	localparam logic [4:0] ASYNC_MID_TICK  = 5'(ASYNC_TICKS_PER_BIT / 2 - 1);
	// engine states
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_STOP  = 2'b10
	} shift_state_e;
endpackage

/* baud_rate_generator.sv */
`timescale 1ns/100ps
// divided tick source; tick every 2*(divisor+1) clocks
module baud_rate_generator
	import serial_pkg::*;
#(
	parameter int DIV_W = 8
)
(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// control
	input  wire logic [DIV_W-1:0] divisor,
	input  wire logic             restart,
	// tick out
	output logic                  tick
);
	logic [1:0]       pre_q;   // fosc/2 prescale
	logic [DIV_W-1:0] cnt_q;   // reload timer

	// free-running reload timer, restart on divisor write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_q <= 2'h0;
			cnt_q <= '0;
			tick  <= 1'b0;
		end
		else if (restart)
		begin
			pre_q <= 2'h0;
			cnt_q <= '0;
			tick  <= 1'b0;
		end
		else
		begin
			tick  <= 1'b0;
			pre_q <= pre_q + 2'h1;
			if (pre_q == TICK_PRESCALE)
			begin
				// prescale wraps at its last count
				pre_q <= 2'h0;
				// reload period divisor+1
				if (cnt_q >= divisor)
				begin
					cnt_q <= '0;
					tick  <= 1'b1;
				end
				else
					cnt_q <= cnt_q + 1'b1;
			end
		end
	end
endmodule // baud_rate_generator

/* char_shifter.sv */
`timescale 1ns/100ps
// shift register for 8 or 9 bit characters, lsb first
module char_shifter
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// control
	input  wire logic       load,
	input  wire logic [8:0] load_data,
	input  wire logic       shift,
	input  wire logic       shift_in,
	// state
	output logic [8:0]      data
);
	// load wins over shift; msb takes shift_in
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data <= 9'h000;
		else if (load)
			data <= load_data;
		else if (shift)
			data <= {shift_in, data[8:1]};
	end
endmodule // char_shifter

/* usart_control_and_baud_gen.sv */
// Local design decision: the APB register port.
`timescale 1ns/100ps
// one serial transceiver; instantiate twice for two ports
module usart_control_and_baud_gen
	import serial_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// rx_data_pin
	input  wire logic        rx_data_pin_i,
	output logic             rx_data_pin_o,
	output logic             rx_data_pin_oe,
	// tx_clock_pin
	input  wire logic        tx_clock_pin_i,
	output logic             tx_clock_pin_o,
	output logic             tx_clock_pin_oe,
	// status
	output logic             serial_active
);
	// control bits
	logic       serial_port_enable_q;
	logic       rx_ninth_bit_select_q;
	logic       single_receive_enable_q;
	logic       continuous_receive_enable_q;
	logic       clock_source_select_q;
	logic       tx_ninth_bit_select_q;
	logic       transmit_enable_q;
	logic       sync_mode_q;
	logic       tx_ninth_data_bit_q;
	logic [7:0] baud_divisor_q;
	// status
	logic       framing_error_flag_q;
	logic       overrun_error_flag_q;
	logic       rx_ninth_data_bit_q;
	logic [7:0] receive_buffer_q;
	logic       rx_full_q;
	logic       rx_frame_err_q;     // pending framing bit of buffered char
	logic [7:0] tx_hold_q;
	logic       tx_hold_full_q;
	// engines
	shift_state_e tx_st_q;
	shift_state_e rx_st_q;
	logic [3:0]   tx_bits_q;
	logic [3:0]   rx_bits_q;
	logic [4:0]   tx_sub_q;
	logic [4:0]   rx_sub_q;
	logic [8:0]   tx_sr;
	logic [8:0]   rx_sr;
	logic         tx_load;
	logic         tx_shift;
	logic         rx_shift;
	logic         tick;
	logic         baud_restart;
	logic         sclk_q;           // master clock level, idles low so the first edge samples
	logic         ext_clk_q;        // previous slave clock sample
	logic         clk_rise;         // sync sample edge
	logic         clk_fall;         // sync shift edge
	logic         receiving;
	logic         rx_done;
	logic         rx_stop_bad;
	// bus decode
	logic         wr_en;
	logic         rd_en;
	logic         hit;

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == RCV_ADDR) || (a == XMT_ADDR) || (a == BAUD_ADDR) ||
			(a == TXD_ADDR) || (a == RXD_ADDR);
	endfunction

	assign hit          = is_mapped(paddr);
	assign wr_en        = psel && penable && pwrite && hit;
	assign rd_en        = psel && penable && !pwrite && hit;
	assign baud_restart = wr_en && (paddr == BAUD_ADDR);
	// generator serves async and sync master only
	assign receiving    = continuous_receive_enable_q || single_receive_enable_q;

	// dedicated 8-bit generator
	baud_rate_generator #(.DIV_W(8)) u_baud_gen
	(
		.pclk    (pclk),
		.presetn (presetn),
		.divisor (baud_divisor_q),
		.restart (baud_restart),
		.tick    (tick)
	);

	// sync clock edges: own divided clock or peer clock
	always_comb
	begin
		if (clock_source_select_q)
		begin
			clk_rise = tick && !sclk_q;
			clk_fall = tick && sclk_q;
		end
		else
		begin
			clk_rise = tx_clock_pin_i && !ext_clk_q;
			clk_fall = !tx_clock_pin_i && ext_clk_q;
		end
	end

	// master clock: one tick per half period, fosc/4(x+1) per bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_q    <= 1'b0;
			ext_clk_q <= 1'b1;
		end
		else
		begin
			ext_clk_q <= tx_clock_pin_i;
			if (!sync_mode_q || !serial_port_enable_q || (tx_st_q == ST_IDLE && rx_st_q == ST_IDLE))
				sclk_q <= 1'b0;
			else if (tick && clock_source_select_q)
				sclk_q <= !sclk_q;
		end
	end

	// apb registers and software side effects
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			serial_port_enable_q        <= RCV_RESET[RC_PORT_EN];
			rx_ninth_bit_select_q       <= RCV_RESET[RC_RX_NINE];
			single_receive_enable_q     <= RCV_RESET[RC_SINGLE_RX];
			continuous_receive_enable_q <= RCV_RESET[RC_CONT_RX];
			clock_source_select_q       <= XMT_RESET[TC_CLK_SRC];
			tx_ninth_bit_select_q       <= XMT_RESET[TC_TX_NINE];
			transmit_enable_q           <= XMT_RESET[TC_TX_EN];
			sync_mode_q                 <= XMT_RESET[TC_SYNC];
			tx_ninth_data_bit_q         <= XMT_RESET[TC_TX_NINTH_DATA];
			baud_divisor_q              <= BAUD_RESET;
			tx_hold_q                   <= 8'h00;
			tx_hold_full_q              <= 1'b0;
		end
		else
		begin
			if (tx_load)
				tx_hold_full_q <= 1'b0;
			// single receive self clears after one byte; write below loses to done
			if (rx_done && sync_mode_q && !continuous_receive_enable_q)
				single_receive_enable_q <= 1'b0;
			if (wr_en)
			begin
				case (paddr)
					RCV_ADDR:
					begin
						serial_port_enable_q        <= pwdata[RC_PORT_EN];
						rx_ninth_bit_select_q       <= pwdata[RC_RX_NINE];
						continuous_receive_enable_q <= pwdata[RC_CONT_RX];
						if (!(rx_done && sync_mode_q))
							single_receive_enable_q <= pwdata[RC_SINGLE_RX];
					end
					XMT_ADDR:
					begin
						clock_source_select_q <= pwdata[TC_CLK_SRC];
						tx_ninth_bit_select_q <= pwdata[TC_TX_NINE];
						transmit_enable_q     <= pwdata[TC_TX_EN];
						sync_mode_q           <= pwdata[TC_SYNC];
						tx_ninth_data_bit_q   <= pwdata[TC_TX_NINTH_DATA];
					end
					BAUD_ADDR:
						baud_divisor_q <= pwdata[7:0];
					TXD_ADDR:
					begin
						tx_hold_q      <= pwdata[7:0];
						tx_hold_full_q <= 1'b1;
					end
					default:
						tx_hold_q <= tx_hold_q;
				endcase
			end
		end
	end

	// transmit engine
	assign tx_load  = (tx_st_q == ST_IDLE) && tx_hold_full_q && transmit_enable_q && serial_port_enable_q;
	assign tx_shift = (tx_st_q == ST_SHIFT) &&
		(sync_mode_q ? clk_fall : (tick && tx_sub_q == ASYNC_LAST_TICK));

	char_shifter u_tx_sr
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.load      (tx_load),
		.load_data ({(tx_ninth_bit_select_q ? tx_ninth_data_bit_q : 1'b1), tx_hold_q}),
		.shift     (tx_shift),
		.shift_in  (1'b1),
		.data      (tx_sr)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_st_q   <= ST_IDLE;
			tx_bits_q <= 4'h0;
			tx_sub_q  <= 5'h00;
		end
		else
		begin
			if (tick && !sync_mode_q)
				tx_sub_q <= tx_sub_q + 5'h01;
			case (tx_st_q)
				ST_IDLE:
					if (tx_load)
					begin
						tx_st_q   <= sync_mode_q ? ST_SHIFT : ST_STOP;
						// 9 or 8 data bits
						// async ends with the stop shift, sync has no stop bit
						tx_bits_q <= (tx_ninth_bit_select_q ? 4'h9 : 4'h8) - (sync_mode_q ? 4'h1 : 4'h0);
						tx_sub_q  <= 5'h00;
					end
				ST_STOP:
					// async start bit time
					if (tick && tx_sub_q == ASYNC_LAST_TICK)
						tx_st_q <= ST_SHIFT;
				ST_SHIFT:
					if (tx_shift)
					begin
						tx_bits_q <= tx_bits_q - 4'h1;
						if (tx_bits_q == 4'h0)
							tx_st_q <= ST_IDLE;
					end
				default:
					tx_st_q <= ST_IDLE;
			endcase
			if (!transmit_enable_q || !serial_port_enable_q)
				tx_st_q <= ST_IDLE;
		end
	end

	// receive engine
	assign rx_shift    = (rx_st_q == ST_SHIFT) &&
		(sync_mode_q ? clk_rise : (tick && rx_sub_q == ASYNC_MID_TICK));
	assign rx_done     = rx_shift && (rx_bits_q == 4'h1);
	assign rx_stop_bad = 1'b0;

	char_shifter u_rx_sr
	(
		.pclk      (pclk),
		.presetn   (presetn),
		.load      (rx_st_q == ST_IDLE),
		.load_data (9'h000),
		.shift     (rx_shift),
		.shift_in  (rx_data_pin_i),
		.data      (rx_sr)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_st_q   <= ST_IDLE;
			rx_bits_q <= 4'h0;
			rx_sub_q  <= 5'h00;
		end
		else
		begin
			if (tick && !sync_mode_q)
				rx_sub_q <= rx_sub_q + 5'h01;
			case (rx_st_q)
				ST_IDLE:
					// async waits for start bit, sync starts at once
					if (receiving && serial_port_enable_q && (sync_mode_q || !rx_data_pin_i))
					begin
						rx_st_q   <= ST_SHIFT;
						// start bit plus data in async
						rx_bits_q <= (rx_ninth_bit_select_q ? 4'h9 : 4'h8) + (sync_mode_q ? 4'h0 : 4'h1);
						rx_sub_q  <= 5'h00;
					end
				ST_SHIFT:
					if (rx_shift)
					begin
						rx_bits_q <= rx_bits_q - 4'h1;
						if (rx_bits_q == 4'h1)
							rx_st_q <= sync_mode_q ? ST_IDLE : ST_STOP;
					end
				ST_STOP:
					if (tick && rx_sub_q == ASYNC_MID_TICK)
						rx_st_q <= ST_IDLE;
				default:
					rx_st_q <= ST_IDLE;
			endcase
			// continuous receive runs until cleared
			if (!receiving || !serial_port_enable_q)
				rx_st_q <= ST_IDLE;
		end
	end

	// receive buffer, overrun and framing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			receive_buffer_q     <= 8'h00;
			rx_ninth_data_bit_q  <= 1'b0;
			rx_full_q            <= 1'b0;
			rx_frame_err_q       <= 1'b0;
			framing_error_flag_q <= 1'b0;
			overrun_error_flag_q <= 1'b0;
		end
		else
		begin
			if (rd_en && paddr == RXD_ADDR)
			begin
				rx_full_q            <= 1'b0;
				framing_error_flag_q <= rx_frame_err_q;
			end
			if (rx_st_q == ST_STOP && tick && rx_sub_q == ASYNC_MID_TICK)
			begin
				if (rx_full_q && !(rd_en && paddr == RXD_ADDR))
					overrun_error_flag_q <= 1'b1;
				else
				begin
					rx_full_q        <= 1'b1;
					receive_buffer_q <= rx_ninth_bit_select_q ? rx_sr[7:0] : rx_sr[8:1];
					rx_ninth_data_bit_q <= rx_ninth_bit_select_q & rx_sr[8];
					rx_frame_err_q   <= !rx_data_pin_i;
				end
			end
			else if (rx_done && sync_mode_q)
			begin
				rx_full_q        <= 1'b1;
				receive_buffer_q <= rx_ninth_bit_select_q ? rx_sr[8:1] : rx_data_pin_i ? {1'b1, rx_sr[8:2]} : {1'b0, rx_sr[8:2]};
				rx_ninth_data_bit_q <= rx_ninth_bit_select_q & rx_data_pin_i;
				rx_frame_err_q   <= rx_stop_bad;
			end
			// overrun stays until continuous receive cleared
			else if (!continuous_receive_enable_q)
				overrun_error_flag_q <= 1'b0;
		end
	end

	// pin drive and apb answer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_data_pin_o   <= 1'b1;
			rx_data_pin_oe  <= 1'b0;
			tx_clock_pin_o  <= 1'b1;
			tx_clock_pin_oe <= 1'b0;
			serial_active   <= 1'b0;
			prdata          <= 32'h0000_0000;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
		end
		else
		begin
			serial_active <= serial_port_enable_q;
			if (!serial_port_enable_q)
			begin
				rx_data_pin_oe  <= 1'b0;
				tx_clock_pin_oe <= 1'b0;
			end
			else if (sync_mode_q)
			begin
				// data out while transmit enabled and not receiving, clock out only as master
				rx_data_pin_oe  <= transmit_enable_q && !receiving;
				rx_data_pin_o   <= (tx_st_q == ST_SHIFT) ? tx_sr[0] : 1'b1;
				tx_clock_pin_oe <= clock_source_select_q;
				tx_clock_pin_o  <= sclk_q;
			end
			else
			begin
				rx_data_pin_oe  <= 1'b0;
				tx_clock_pin_oe <= transmit_enable_q;
				tx_clock_pin_o  <= (tx_st_q == ST_STOP) ? 1'b0 : (tx_st_q == ST_SHIFT) ? tx_sr[0] : 1'b1;
			end
			// no wait state: ready in the first access cycle
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !hit;
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					RCV_ADDR:  prdata <= {24'h0, serial_port_enable_q, rx_ninth_bit_select_q,
						single_receive_enable_q, continuous_receive_enable_q, 1'b0,
						framing_error_flag_q, overrun_error_flag_q, rx_ninth_data_bit_q};
					XMT_ADDR:  prdata <= {24'h0, clock_source_select_q, tx_ninth_bit_select_q,
						transmit_enable_q, sync_mode_q, 2'b00, (tx_st_q == ST_IDLE), tx_ninth_data_bit_q};
					BAUD_ADDR: prdata <= {24'h0, baud_divisor_q};
					RXD_ADDR:  prdata <= {24'h0, receive_buffer_q};
					default:   prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // usart_control_and_baud_gen

/* usart_control_and_baud_gen_sva.sv */
`timescale 1ns/100ps
// bus and pin checks at the transceiver ports
module usart_sva
	import serial_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// pins
	input wire logic        rx_data_pin_oe,
	input wire logic        tx_clock_pin_oe,
	input wire logic        serial_active
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// decoded word addresses
	logic mapped;
	// helper decode
	assign mapped = paddr inside {RCV_ADDR, XMT_ADDR, BAUD_ADDR, TXD_ADDR, RXD_ADDR};
	a_ready_after_setup:
		assert property (psel && !penable |=> pready) else $error("no ready in first access cycle");
	a_ready_one_cycle:
		assert property (pready |=> !pready) else $error("ready longer than one cycle");
	a_idle_no_ready:
		assert property (!psel |=> !pready) else $error("ready without select");
	a_err_unmapped:
		assert property (pready && !mapped |-> pslverr) else $error("unmapped access not refused");
	a_ok_mapped:
		assert property (pready && mapped |-> !pslverr) else $error("mapped access refused");
	a_err_zero_data:
		assert property (pslverr |-> pready && prdata == 32'h00000000) else $error("bad error answer");
	a_upper_zero:
		assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper read bits set");
	a_port_on:
		assert property (psel && penable && pready && pwrite && paddr == RCV_ADDR && pwdata[RC_PORT_EN]
			|-> ##[1:2] serial_active) else $error("port enable not taken");
	a_port_off:
		assert property (psel && penable && pready && pwrite && paddr == RCV_ADDR && !pwdata[RC_PORT_EN]
			|-> ##[1:2] !serial_active) else $error("port disable not taken");
	a_pins_need_enable:
		assert property (!serial_active && !$past(serial_active) |-> !rx_data_pin_oe && !tx_clock_pin_oe)
			else $error("pin driven with port off");
endmodule // usart_sva

bind usart_control_and_baud_gen usart_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rx_data_pin_oe(rx_data_pin_oe), .tx_clock_pin_oe(tx_clock_pin_oe),
	.serial_active(serial_active));

/* serial_peer_model.sv */
`timescale 1ns/100ps
// asynchronous terminal on the far side of the pins
module serial_peer_model
(
	// clock
	input  wire logic pclk,
	// serial lines
	input  wire logic line_in,
	output logic      line_out,
	// frame setup
	input  wire logic [31:0] bit_clks,
	input  wire logic nine,
	// last character taken
	output logic [8:0] got
);
	// idle line high
	initial line_out = 1'b1;
	// one frame out: start, data lsb first, stop
	task automatic send(input logic [8:0] c, input int n);
		line_out <= 1'b0;
		repeat (bit_clks) @(posedge pclk);
		for (int i = 0; i < n; i++)
		begin
			line_out <= c[i];
			repeat (bit_clks) @(posedge pclk);
		end
		line_out <= 1'b1;
		repeat (bit_clks) @(posedge pclk);
	endtask
	// frame in, sampled at mid bit
	always
	begin
		@(negedge line_in);
		got = 9'h000;
		repeat (bit_clks / 2) @(posedge pclk);
		for (int i = 0; i < 9; i++)
		begin
			repeat (bit_clks) @(posedge pclk);
			if (i < 8 || nine)
				got[i] = line_in;
		end
		repeat (bit_clks) @(posedge pclk);
	end
endmodule // serial_peer_model

/* tb_usart_control_and_baud_gen.sv */
`timescale 1ns/100ps
// register, frame and reset tests
module tb_usart_control_and_baud_gen
	import serial_pkg::*;
;
	// row: address, write data, read value, error
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_s;
	localparam int BIT_CLKS = 64 * (1 + 1);
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic        pready, pslverr, rd_e;
	logic        rx_o, rx_oe, tx_o, tx_oe, peer_line, nine;
	logic [8:0]  got;
	int          mismatches, tests_run;
	logic [7:0]  sync_bits;             // sync master bits, lsb first
	int          sync_rises;            // rising pin clock edges seen
	logic        sync_on;               // capture window
	row_s        rows [4] = '{
		'{BAUD_ADDR, 32'h000000a5, 32'h000000a5, 1'b0},
		'{XMT_ADDR, 32'hffffffcd, 32'h000000c3, 1'b0},
		'{RCV_ADDR, 32'h0000004f, 32'h00000040, 1'b0},
		'{12'hffc, 32'h00000012, 32'h00000000, 1'b1}};
	// wire levels from all enables
	wire logic rx_wire = rx_oe ? rx_o : peer_line;
	wire logic tx_wire = tx_oe ? tx_o : 1'b1;
	usart_control_and_baud_gen u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_data_pin_i(rx_wire), .rx_data_pin_o(rx_o), .rx_data_pin_oe(rx_oe),
		.tx_clock_pin_i(tx_wire), .tx_clock_pin_o(tx_o), .tx_clock_pin_oe(tx_oe), .serial_active());
	serial_peer_model u_peer (.pclk(pclk), .line_in(tx_wire), .line_out(peer_line),
		.bit_clks(BIT_CLKS), .nine(nine), .got(got));
	// clock
	always #5 pclk = ~pclk;
	// sync master capture on the rising pin clock
	always @(posedge tx_wire)
		if (sync_on)
		begin
			sync_bits = {rx_wire, sync_bits[7:1]};
			sync_rises++;
		end
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x)
		begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// one transfer held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 40);
		chk({31'h0, pready}, 32'h1);
		rd_q = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read and compare
	task automatic rd(input logic [11:0] a, input logic [31:0] q);
		apb(1'b0, a, 32'h0);
		chk(rd_q, q);
	endtask
	// verdict
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		nine = 1'b0;
		mismatches = 0;
		tests_run = 0;
		sync_on = 1'b0;
		sync_rises = 0;
		sync_bits = 8'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(RCV_ADDR, {24'h0, RCV_RESET});
		rd(XMT_ADDR, {24'h0, XMT_RESET});
		rd(BAUD_ADDR, 32'h0);
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk({31'h0, rd_e}, {31'h0, rows[i].e});
			rd(rows[i].a, rows[i].q);
		end
		$display("register test done");
		apb(1'b1, BAUD_ADDR, 32'h1);
		apb(1'b1, RCV_ADDR, 32'h90);
		apb(1'b1, XMT_ADDR, 32'h20);
		fork
			u_peer.send(9'h0c6, 8);
			apb(1'b1, TXD_ADDR, 32'ha3);
		join
		repeat (300) @(posedge pclk);
		chk({23'h0, got}, 32'h0a3);
		rd(RXD_ADDR, 32'hc6);
		rd(XMT_ADDR, 32'h22);
		$display("eight bit test done");
		nine = 1'b1;
		apb(1'b1, RCV_ADDR, 32'hd0);
		apb(1'b1, XMT_ADDR, 32'h61);
		fork
			u_peer.send(9'h15a, 9);
			apb(1'b1, TXD_ADDR, 32'h3c);
		join
		repeat (300) @(posedge pclk);
		chk({23'h0, got}, 32'h13c);
		rd(RXD_ADDR, 32'h5a);
		rd(RCV_ADDR, 32'hd1);
		$display("nine bit test done");
		nine = 1'b0;
		apb(1'b1, RCV_ADDR, 32'h90);
		u_peer.send(9'h011, 8);
		u_peer.send(9'h022, 8);
		repeat (300) @(posedge pclk);
		rd(RCV_ADDR, 32'h92);
		rd(RXD_ADDR, 32'h11);
		apb(1'b1, RCV_ADDR, 32'h80);
		rd(RCV_ADDR, 32'h80);
		$display("overrun test done");
		sync_on = 1'b1;
		apb(1'b1, XMT_ADDR, 32'hb0);
		apb(1'b1, TXD_ADDR, 32'h5a);
		repeat (120) @(posedge pclk);
		sync_on = 1'b0;
		chk({24'h0, sync_bits}, 32'h5a);
		chk(sync_rises, 32'h8);
		rd(XMT_ADDR, 32'hb2);
		$display("sync test done");
		apb(1'b1, BAUD_ADDR, 32'ha5);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(BAUD_ADDR, 32'h0);
		rd(RCV_ADDR, 32'h0);
		$display("reset test done");
		report_and_stop();
	end
	// watchdog
	initial
	begin
		#400000;
		mismatches++;
		report_and_stop();
	end
endmodule // tb_usart_control_and_baud_gen
